// *** hdl/tft_consts.svh ***
// Constants of the T1 frame timing engine: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the package and design files.
`ifndef TFT_CONSTS_SVH
`define TFT_CONSTS_SVH

// Frame geometry
`define TFT_CHANNELS 24
`define TFT_BITS_PER_CHAN 8
`define TFT_LAST_POS 8'd192
`define TFT_D4_FRAMES 5'd12
`define TFT_ESF_FRAMES 5'd24

// Framing patterns, bit n belongs to frame n+1 (D4) or frame 4n+4 (ESF)
`define TFT_D4_PATTERN 12'h3b1
`define TFT_ESF_PATTERN 6'h34
`define TFT_CRC6_POLY 6'h03

// Register offsets on the plain port
`define TFT_OFF_TX_ESC 4'h0
`define TFT_OFF_RX_ESC 4'h1
`define TFT_OFF_TX_SEL 4'h2
`define TFT_OFF_RX_SEL 4'h3
`define TFT_OFF_MODE 4'h4
`define TFT_OFF_STATUS 4'h5

// Field positions
`define TFT_ESC_GAP_EN_BIT 6
`define TFT_ESC_FMT56_BIT 7
`define TFT_MODE_ESF_BIT 0
`define TFT_MODE_JY_BIT 1

// Reset values
`define TFT_ESC_RESET 8'h00
`define TFT_SEL_RESET 24'h000000
`define TFT_MODE_RESET 2'h0

// Receive alignment counts
`define TFT_SYNC_MATCHES 8'd24
`define TFT_LOSS_ERRORS 2'd3

`endif

// *** hdl/tft_pkg.sv ***
// Types of the T1 frame timing engine.
// Assumes tft_consts.svh is on the include path.
`include "tft_consts.svh"

package tft_pkg;

    // Receive alignment states
    typedef enum logic [1:0] {
        TFT_HUNT = 2'b00,
        TFT_VERIFY = 2'b01,
        TFT_LOCKED = 2'b10
    } tft_rx_state_t;

    // Bit position inside a frame, 0 is the framing bit
    typedef logic [7:0] tft_pos_t;

    // Frame number inside a superframe, counted from 0
    typedef logic [4:0] tft_frame_t;

endpackage

// *** hdl/tft_gap_if.sv ***
// Interface between the frame counters and one gapped clock generator.
// Assumes both ends run on mclk_in.
`timescale 1ns/1ps
`default_nettype none

interface tft_gap_if;
    logic clk_level; // Synchronised bit clock level
    logic fbit; // Framing bit time
    logic [4:0] chan; // Channel 0..23
    logic [2:0] bitpos; // Bit 0 is the MSB
    logic enable; // Gapped clock enable
    logic fmt56; // 56kbps format
    logic [23:0] select; // Channel bitmap
    logic chclk; // Gapped clock back

    modport src (output clk_level, fbit, chan, bitpos, enable, fmt56, select, input chclk);
    modport gap (input clk_level, fbit, chan, bitpos, enable, fmt56, select, output chclk);
endinterface

`default_nettype wire

// *** hdl/tft_gap_clock.sv ***
// Gapped channel clock for one path.
// Assumes position fields and clock level are already on mclk_in.
`timescale 1ns/1ps
`default_nettype none

module tft_gap_clock (
    input wire logic mclk_in,
    input wire logic reset_in,
    tft_gap_if.gap g
);

    logic lvl_q; // Bit clock level one cycle late

    ////////////////////////////////////////////////////////////////////////
    // Delayed level, so the new bit's fields settle before its high phase
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            lvl_q <= 1'b0;
        end else begin
            lvl_q <= g.clk_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock follows the delayed level only in gated bit times, no edge glitch
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            g.chclk <= 1'b0;
        end else begin
            g.chclk <= lvl_q && g.enable && !g.fbit && g.select[g.chan]
                && !(g.fmt56 && g.bitpos == 3'h7);
        end
    end

endmodule

`default_nettype wire

// *** hdl/tft_frame_timing.sv ***
// T1 frame timing engine with gapped channel clocks.
// Assumes line bit clocks far slower than mclk_in and a plain register port.
//
// Summary of operation
// - Transmit channel clock only in selected channels
// - Receive channel clock only in selected channels
// - Config bit 7 picks 56k or 64k
// - 56k format drops the LSB clock
// - Frame is 24 channels plus F-bit
// - One framing bit at frame start
// - Superframe 12 frames D4, 24 ESF
// - D4 odd frames carry 101010
// - D4 even frames carry 001110
// - Japanese yellow ignores D4 frame 12 bit
// - ESF pattern 0,0,1,0,1,1 in frames 4..24
// - ESF CRC-6 in frames 2..22
// - Receiver aligns and marks frame boundaries
`timescale 1ns/1ps
`default_nettype none
`include "tft_consts.svh"

module tft_frame_timing #(
    parameter logic [7:0] SYNC_MATCHES = `TFT_SYNC_MATCHES
) (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rd_data_out,
    input wire logic tx_bit_clk_in,
    input wire logic tx_data_in,
    input wire logic tx_fdl_in,
    output logic tx_data_out,
    output logic tx_frame_sync_out,
    output logic tx_superframe_sync_out,
    output logic tx_channel_clock_out,
    input wire logic rx_bit_clk_in,
    input wire logic rx_data_in,
    output logic rx_frame_sync_out,
    output logic rx_superframe_sync_out,
    output logic rx_in_sync_out,
    output logic rx_channel_clock_out
);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Superframe length of the selected mode
    function automatic tft_pkg::tft_frame_t frames_of(input logic esf);
        frames_of = esf ? `TFT_ESF_FRAMES : `TFT_D4_FRAMES;
    endfunction

    // Next frame number with wrap
    function automatic tft_pkg::tft_frame_t next_frame(input tft_pkg::tft_frame_t f,
                                                      input logic esf);
        next_frame = (f == frames_of(esf) - 5'd1) ? 5'd0 : f + 5'd1;
    endfunction

    // Expected framing bit for frame f
    function automatic logic fbit_of(input logic esf, input tft_pkg::tft_frame_t f,
                                     input logic [5:0] crc, input logic facility_data_link);
        if (!esf) begin
            fbit_of = 1'(`TFT_D4_PATTERN >> f);
        end else if (!f[0]) begin
            fbit_of = facility_data_link;
        end else if (f[1:0] == 2'h3) begin
            fbit_of = 1'(`TFT_ESF_PATTERN >> f[4:2]);
        end else begin
            fbit_of = crc[3'd5 - f[4:2]];
        end
    endfunction

    // Framing bit checked by the receiver
    function automatic logic fbit_checked(input logic esf, input logic jy,
                                          input tft_pkg::tft_frame_t f);
        if (esf) begin
            fbit_checked = (f[1:0] == 2'h3);
        end else begin
            fbit_checked = !(jy && f == 5'd11);
        end
    endfunction

    // One CRC-6 step
    function automatic logic [5:0] crc_step(input logic [5:0] c, input logic b);
        crc_step = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? `TFT_CRC6_POLY : 6'h00);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0] tx_esc_q; // Transmit elastic store config
    logic [7:0] rx_esc_q; // Receive elastic store config
    logic [23:0] tx_sel_q; // Transmit gap channel select
    logic [23:0] rx_sel_q; // Receive gap channel select
    logic [1:0] mode_q; // ESF and Japanese yellow
    tft_pkg::tft_pos_t rx_pos_q; // Receive bit position
    tft_pkg::tft_frame_t rx_frm_q; // Receive frame number
    tft_pkg::tft_rx_state_t rx_state_q; // Receive alignment state

    // Register writes
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_esc_q <= `TFT_ESC_RESET;
            rx_esc_q <= `TFT_ESC_RESET;
            tx_sel_q <= `TFT_SEL_RESET;
            rx_sel_q <= `TFT_SEL_RESET;
            mode_q <= `TFT_MODE_RESET;
        end else if (wr_in) begin
            unique case (addr_in)
                `TFT_OFF_TX_ESC: tx_esc_q <= wr_data_in[7:0];
                `TFT_OFF_RX_ESC: rx_esc_q <= wr_data_in[7:0];
                `TFT_OFF_TX_SEL: tx_sel_q <= wr_data_in[23:0];
                `TFT_OFF_RX_SEL: rx_sel_q <= wr_data_in[23:0];
                `TFT_OFF_MODE: mode_q <= wr_data_in[1:0];
                default: ; // Unmapped writes ignored
            endcase
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_out <= 32'h00000000;
        end else if (rd_in) begin
            unique case (addr_in)
                `TFT_OFF_TX_ESC: rd_data_out <= {24'h000000, tx_esc_q};
                `TFT_OFF_RX_ESC: rd_data_out <= {24'h000000, rx_esc_q};
                `TFT_OFF_TX_SEL: rd_data_out <= {8'h00, tx_sel_q};
                `TFT_OFF_RX_SEL: rd_data_out <= {8'h00, rx_sel_q};
                `TFT_OFF_MODE: rd_data_out <= {30'h00000000, mode_q};
                `TFT_OFF_STATUS: rd_data_out <= {16'h0000, rx_pos_q,
                                                 1'b0, rx_frm_q, rx_state_q};
                default: rd_data_out <= 32'h00000000; // Unmapped read zero
            endcase
        end else begin
            rd_data_out <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, first stage read only by the second

    logic [4:0] meta_q; // First stage
    logic [4:0] sync_q; // Second stage
    logic tx_clk_prev_q; // Edge detector history
    logic rx_clk_prev_q; // Edge detector history

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q <= 5'h00;
            sync_q <= 5'h00;
            tx_clk_prev_q <= 1'b0;
            rx_clk_prev_q <= 1'b0;
        end else begin
            meta_q <= {rx_data_in, rx_bit_clk_in, tx_fdl_in, tx_data_in, tx_bit_clk_in};
            sync_q <= meta_q;
            tx_clk_prev_q <= sync_q[0];
            rx_clk_prev_q <= sync_q[3];
        end
    end

    logic tx_rise; // Transmit bit clock rising edge
    logic rx_rise; // Receive bit clock rising edge
    assign tx_rise = sync_q[0] && !tx_clk_prev_q;
    assign rx_rise = sync_q[3] && !rx_clk_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Transmit frame counters and framing bit insertion

    tft_pkg::tft_pos_t tx_pos_q; // Bit position, 0 is the F-bit
    tft_pkg::tft_frame_t tx_frm_q; // Frame number
    logic [5:0] tx_crc_q; // CRC being built
    logic [5:0] tx_crc_send_q; // CRC of previous superframe
    logic tx_started_q; // First edge seen
    tft_pkg::tft_frame_t tx_frm_new; // Frame opened by the next F-bit

    // First frame after reset is frame 1, later ones advance
    assign tx_frm_new = tx_started_q ? next_frame(tx_frm_q, mode_q[`TFT_MODE_ESF_BIT]) :
                                       tx_frm_q;

    // Position and frame counting
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_pos_q <= `TFT_LAST_POS;
            tx_frm_q <= 5'd0;
            tx_started_q <= 1'b0;
        end else if (tx_rise) begin
            tx_started_q <= 1'b1;
            if (tx_pos_q == `TFT_LAST_POS) begin
                tx_pos_q <= 8'd0;
                tx_frm_q <= tx_frm_new;
            end else begin
                tx_pos_q <= tx_pos_q + 8'd1;
            end
        end
    end

    // CRC over the superframe, F-bits counted as ones
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_crc_q <= 6'h00;
            tx_crc_send_q <= 6'h00;
        end else if (tx_rise && tx_started_q) begin
            if (tx_pos_q == `TFT_LAST_POS &&
                tx_frm_q == frames_of(mode_q[`TFT_MODE_ESF_BIT]) - 5'd1) begin
                tx_crc_send_q <= crc_step(tx_crc_q, sync_q[1]);
                tx_crc_q <= 6'h00;
            end else begin
                tx_crc_q <= crc_step(tx_crc_q, tx_pos_q == 8'd0 ? 1'b1 : sync_q[1]);
            end
        end
    end

    // Line data: F-bit at position 0, payload after it
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_data_out <= 1'b0;
            tx_frame_sync_out <= 1'b0;
            tx_superframe_sync_out <= 1'b0;
        end else if (tx_rise) begin
            if (tx_pos_q == `TFT_LAST_POS) begin
                tx_data_out <= fbit_of(mode_q[`TFT_MODE_ESF_BIT], tx_frm_new,
                                       tx_crc_send_q, sync_q[2]);
                tx_frame_sync_out <= 1'b1;
                tx_superframe_sync_out <= (tx_frm_new == 5'd0);
            end else begin
                tx_data_out <= sync_q[1];
                tx_frame_sync_out <= 1'b0;
                tx_superframe_sync_out <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive alignment

    logic [7:0] rx_match_q; // Consecutive good F-bits
    logic [1:0] rx_err_q; // Consecutive bad F-bits when locked
    logic rx_f_chk; // Current F-bit is checked
    logic rx_f_bad; // Current F-bit mismatches
    logic rx_hold; // Slip one bit this edge
    tft_pkg::tft_frame_t rx_frm_next; // Frame after this one

    assign rx_f_chk = fbit_checked(mode_q[`TFT_MODE_ESF_BIT], mode_q[`TFT_MODE_JY_BIT],
                                   rx_frm_q);
    assign rx_f_bad = rx_f_chk && (sync_q[4] != fbit_of(mode_q[`TFT_MODE_ESF_BIT],
                                   rx_frm_q, 6'h00, 1'b0));
    assign rx_hold = (rx_pos_q == 8'd0) && rx_f_bad && rx_state_q != tft_pkg::TFT_LOCKED;
    assign rx_frm_next = next_frame(rx_frm_q, mode_q[`TFT_MODE_ESF_BIT]);

    // Counters, slipping one bit on every bad F-bit while hunting or verifying
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_pos_q <= 8'd0;
            rx_frm_q <= 5'd0;
        end else if (rx_rise) begin
            if (rx_hold) begin
                rx_pos_q <= 8'd0;
                rx_frm_q <= rx_frm_next; // Walks frame phase too
            end else if (rx_pos_q == `TFT_LAST_POS) begin
                rx_pos_q <= 8'd0;
                rx_frm_q <= rx_frm_next;
            end else begin
                rx_pos_q <= rx_pos_q + 8'd1;
            end
        end
    end

    // Alignment state
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_state_q <= tft_pkg::TFT_HUNT;
            rx_match_q <= 8'd0;
            rx_err_q <= 2'd0;
        end else if (rx_rise && rx_pos_q == 8'd0 && rx_f_chk) begin
            unique case (rx_state_q)
                tft_pkg::TFT_HUNT, tft_pkg::TFT_VERIFY: begin
                    if (rx_f_bad) begin
                        rx_state_q <= tft_pkg::TFT_HUNT;
                        rx_match_q <= 8'd0;
                    end else if (rx_match_q == SYNC_MATCHES - 8'd1) begin
                        rx_state_q <= tft_pkg::TFT_LOCKED;
                        rx_err_q <= 2'd0;
                    end else begin
                        rx_state_q <= tft_pkg::TFT_VERIFY;
                        rx_match_q <= rx_match_q + 8'd1;
                    end
                end
                tft_pkg::TFT_LOCKED: begin
                    if (!rx_f_bad) begin
                        rx_err_q <= 2'd0;
                    end else if (rx_err_q == `TFT_LOSS_ERRORS - 2'd1) begin
                        rx_state_q <= tft_pkg::TFT_HUNT; // Lost alignment
                        rx_match_q <= 8'd0;
                    end else begin
                        rx_err_q <= rx_err_q + 2'd1;
                    end
                end
                default: rx_state_q <= tft_pkg::TFT_HUNT; // Illegal code
            endcase
        end
    end

    // Boundary marks, only while aligned
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_frame_sync_out <= 1'b0;
            rx_superframe_sync_out <= 1'b0;
            rx_in_sync_out <= 1'b0;
        end else begin
            rx_in_sync_out <= (rx_state_q == tft_pkg::TFT_LOCKED);
            rx_frame_sync_out <= (rx_state_q == tft_pkg::TFT_LOCKED) &&
                                 rx_pos_q == 8'd0;
            rx_superframe_sync_out <= (rx_state_q == tft_pkg::TFT_LOCKED) &&
                                      rx_pos_q == 8'd0 && rx_frm_q == 5'd0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gapped clocks

    tft_gap_if tx_gap ();
    tft_gap_if rx_gap ();

    // Transmit path fields
    assign tx_gap.clk_level = sync_q[0];
    assign tx_gap.fbit = (tx_pos_q == 8'd0);
    assign tx_gap.chan = tx_gap.fbit ? 5'd0 : 5'((tx_pos_q - 8'd1) >> 3);
    assign tx_gap.bitpos = tx_gap.fbit ? 3'd0 : 3'(tx_pos_q - 8'd1);
    assign tx_gap.enable = tx_esc_q[`TFT_ESC_GAP_EN_BIT] && tx_started_q;
    assign tx_gap.fmt56 = tx_esc_q[`TFT_ESC_FMT56_BIT];
    assign tx_gap.select = tx_sel_q;
    assign tx_channel_clock_out = tx_gap.chclk;

    // Receive path fields, silent until aligned
    assign rx_gap.clk_level = sync_q[3];
    assign rx_gap.fbit = (rx_pos_q == 8'd0);
    assign rx_gap.chan = rx_gap.fbit ? 5'd0 : 5'((rx_pos_q - 8'd1) >> 3);
    assign rx_gap.bitpos = rx_gap.fbit ? 3'd0 : 3'(rx_pos_q - 8'd1);
    assign rx_gap.enable = rx_esc_q[`TFT_ESC_GAP_EN_BIT] &&
                           rx_state_q == tft_pkg::TFT_LOCKED;
    assign rx_gap.fmt56 = rx_esc_q[`TFT_ESC_FMT56_BIT];
    assign rx_gap.select = rx_sel_q;
    assign rx_channel_clock_out = rx_gap.chclk;

    // One generator per path
    tft_gap_clock u_tx_gap (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .g(tx_gap.gap)
    );

    tft_gap_clock u_rx_gap (
        .mclk_in(mclk_in),
        .reset_in(reset_in),
        .g(rx_gap.gap)
    );

endmodule

`default_nettype wire

// *** dv/tft_hdlc_peer.sv ***
// Serial controller model fed by the gapped clocks and the frame mark.
// Assumes every input is sampled on mclk_in.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////
module tft_hdlc_peer (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic tx_clk_in,
    input wire logic rx_clk_in,
    input wire logic fsync_in,
    output logic data_out,
    output logic fdl_out,
    output logic [15:0] tx_cnt_out,
    output logic [15:0] rx_cnt_out
);
    logic tx_q; // Last gapped clock levels
    logic rx_q;
    logic fs_q; // Last frame mark level
    // New data bit per clock rise; link bit flips once the framing bit has gone
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            {tx_q, rx_q, fs_q, data_out, fdl_out} <= 5'h00;
            tx_cnt_out <= 16'h0000;
            rx_cnt_out <= 16'h0000;
        end else begin
            {tx_q, rx_q, fs_q} <= {tx_clk_in, rx_clk_in, fsync_in};
            if (tx_clk_in && !tx_q) begin
                data_out <= ~data_out;
                tx_cnt_out <= tx_cnt_out + 16'h0001;
            end
            if (rx_clk_in && !rx_q) rx_cnt_out <= rx_cnt_out + 16'h0001;
            if (fs_q && !fsync_in) fdl_out <= ~fdl_out;
        end
    end
endmodule
`default_nettype wire

// *** dv/tft_frame_timing_monitor.sv ***
// Checker on the top ports of the frame timing engine.
// Assumes one clock domain, mclk_in, with reset_in asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "tft_consts.svh"
////////////////////////////////////////////////////////////////
module tft_frame_timing_monitor (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic tx_bit_clk_in,
    input wire logic tx_frame_sync_out,
    input wire logic tx_superframe_sync_out,
    input wire logic tx_channel_clock_out,
    input wire logic rx_frame_sync_out,
    input wire logic rx_superframe_sync_out,
    input wire logic rx_in_sync_out,
    input wire logic rx_channel_clock_out
);
    logic tx_en_q; // Shadow of the gap enables
    logic rx_en_q;
    logic bclk_q; // Last raw bit clock level
    logic fs_q; // Last frame mark level
    logic seen_q; // A frame mark has been seen
    logic [8:0] bits_q; // Bit clock rises since the last frame mark
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    // Gap enable shadows follow register writes
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_en_q <= 1'h0;
            rx_en_q <= 1'h0;
        end else if (wr_in && addr_in == `TFT_OFF_TX_ESC) begin
            tx_en_q <= wr_data_in[`TFT_ESC_GAP_EN_BIT];
        end else if (wr_in && addr_in == `TFT_OFF_RX_ESC) begin
            rx_en_q <= wr_data_in[`TFT_ESC_GAP_EN_BIT];
        end
    end
    // Bit times per transmit frame
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            {bclk_q, fs_q, seen_q} <= 3'h0;
            bits_q <= 9'h000;
        end else begin
            bclk_q <= tx_bit_clk_in;
            fs_q <= tx_frame_sync_out;
            if (tx_frame_sync_out && !fs_q) begin
                seen_q <= 1'h1;
                bits_q <= 9'(tx_bit_clk_in && !bclk_q);
            end else begin
                bits_q <= bits_q + 9'(tx_bit_clk_in && !bclk_q);
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    a_tx_gap_off: assert property (
        !tx_en_q && !$past(tx_en_q) && !$past(tx_en_q, 2) |-> !tx_channel_clock_out)
        else $error("tx channel clock while disabled");
    a_rx_gap_off: assert property (
        !rx_en_q && !$past(rx_en_q) && !$past(rx_en_q, 2) |-> !rx_channel_clock_out)
        else $error("rx channel clock while disabled");
    a_no_fbit_clock: assert property (
        tx_channel_clock_out |-> !tx_frame_sync_out)
        else $error("tx channel clock in framing bit");
    a_tx_frame_len: assert property (
        $rose(tx_frame_sync_out) && seen_q |-> bits_q == 9'd193)
        else $error("tx frame length wrong");
    a_tx_sf_frame: assert property (
        tx_superframe_sync_out |-> tx_frame_sync_out)
        else $error("tx superframe mark off frame mark");
    a_rx_sf_frame: assert property (
        rx_superframe_sync_out |-> rx_frame_sync_out)
        else $error("rx superframe mark off frame mark");
    a_rx_frame_lock: assert property (
        rx_frame_sync_out |-> rx_in_sync_out)
        else $error("rx frame mark while unlocked");
    a_rx_clk_lock: assert property (
        rx_channel_clock_out |-> rx_in_sync_out && !rx_frame_sync_out)
        else $error("rx channel clock unlocked or in framing bit");
endmodule
bind tft_frame_timing tft_frame_timing_monitor mon (
    .mclk_in, .reset_in, .addr_in, .wr_data_in, .wr_in, .tx_bit_clk_in,
    .tx_frame_sync_out, .tx_superframe_sync_out, .tx_channel_clock_out,
    .rx_frame_sync_out, .rx_superframe_sync_out, .rx_in_sync_out, .rx_channel_clock_out
);
`default_nettype wire

// *** dv/tb_top.sv ***
// Testbench: register port, looped-back line, gap clocks and framing bits.
// Assumes a 100 MHz mclk_in and a 160 ns free running line clock.
`timescale 1ns/1ps
`default_nettype none
`include "tft_consts.svh"
////////////////////////////////////////////////////////////////
module tb_top;
    logic mclk_in = 1'h0;
    logic reset_in = 1'h1;
    logic [3:0] addr_in = 4'h0; // Register port
    logic [31:0] wr_data_in = 32'h0;
    logic wr_in = 1'h0;
    logic rd_in = 1'h0;
    logic tx_clk = 1'h0; // Line clock, rx copy half a bit late
    logic rx_clk = 1'h0;
    wire logic [31:0] rd_data_out;
    wire logic tx_d, tx_fdl, tx_out, tx_fs, tx_sf, tx_ck, rx_fs, rx_sf, rx_lk, rx_ck;
    wire logic [15:0] tx_cnt, rx_cnt;
    logic [15:0] tx_last, rx_last; // Pulse counts at the last frame mark
    logic [31:0] rv;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    int w;
    localparam logic [11:0] D4F = 12'h3b1; // Bit n-1 is the framing bit of frame n
    localparam logic [5:0] ESFF = 6'h34; // Frames 4, 8, 12, 16, 20, 24
    always #5 mclk_in = ~mclk_in;
    initial #3 forever #80 tx_clk = ~tx_clk;
    always @(tx_clk) rx_clk <= #80 tx_clk;
    tft_frame_timing #(.SYNC_MATCHES(8'h04)) uut (
        .mclk_in, .reset_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
        .tx_bit_clk_in(tx_clk), .tx_data_in(tx_d), .tx_fdl_in(tx_fdl), .tx_data_out(tx_out),
        .tx_frame_sync_out(tx_fs), .tx_superframe_sync_out(tx_sf),
        .tx_channel_clock_out(tx_ck), .rx_bit_clk_in(rx_clk), .rx_data_in(tx_out),
        .rx_frame_sync_out(rx_fs), .rx_superframe_sync_out(rx_sf),
        .rx_in_sync_out(rx_lk), .rx_channel_clock_out(rx_ck));
    tft_hdlc_peer peer (.mclk_in, .reset_in, .tx_clk_in(tx_ck), .rx_clk_in(rx_ck),
        .fsync_in(tx_fs), .data_out(tx_d), .fdl_out(tx_fdl),
        .tx_cnt_out(tx_cnt), .rx_cnt_out(rx_cnt));
    ////////////////////////////////////////////////////////////////
    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'h1;
        @(posedge mclk_in);
        wr_in <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge mclk_in);
        rd_in <= 1'h0;
        #1 d = rd_data_out;
    endtask
    // Bounded wait for a frame mark level
    task automatic wait_lvl(input logic v);
        w = 0;
        while (tx_fs !== v) begin
            @(posedge mclk_in);
            #1;
            w++;
            if (w > 4000) begin
                error_cnt++;
                $display("BAD %0t frame mark missing", $time);
                final_report();
            end
        end
    endtask
    // Reset values, unmapped place, field widths, then gap setup
    task automatic setup();
        for (int a = 0; a < 7; a++) begin
            if (a != 5) begin
                rd(4'(a), rv);
                compare(rv, 32'h0);
            end
        end
        wr(4'h6, 32'hffffffff);
        rd(4'h6, rv);
        compare(rv, 32'h0);
        wr(`TFT_OFF_TX_SEL, 32'hffffffff);
        rd(`TFT_OFF_TX_SEL, rv);
        compare(rv, 32'h00ffffff);
        wr(`TFT_OFF_MODE, 32'hfffffffe);
        rd(`TFT_OFF_MODE, rv);
        compare(rv, 32'h2);
        wr(`TFT_OFF_MODE, 32'h0);
        wr(`TFT_OFF_TX_ESC, 32'hc0);
        wr(`TFT_OFF_TX_SEL, 32'h1);
        wr(`TFT_OFF_RX_ESC, 32'h40);
        wr(`TFT_OFF_RX_SEL, 32'h800);
        rd(`TFT_OFF_TX_ESC, rv);
        compare(rv, 32'hc0);
    endtask
    // D4 superframe, then ESF from frame 13 to frame 4 of the next
    initial begin
        repeat (12) @(posedge mclk_in);
        reset_in <= 1'h0;
        fork
            setup();
        join_none
        for (int i = 0; i < 28; i++) begin
            wait_lvl(1'h1);
            n = (i < 24) ? i + 1 : i - 23;
            compare(tx_sf, n == 1);
            if (i < 12) begin
                compare(tx_out, D4F[n-1]);
            end else if (n % 4 == 0) begin
                compare(tx_out, ESFF[n/4-1]);
            end else if (n % 2 == 1) begin
                compare(tx_out, tx_fdl);
            end
            if (i >= 2) compare(tx_cnt - tx_last, i < 6 ? 7 : (i < 9 ? 8 : 0));
            if (i >= 10) compare(rx_cnt - rx_last, 8);
            tx_last = tx_cnt;
            rx_last = rx_cnt;
            if (i == 5) wr(`TFT_OFF_TX_ESC, 32'h40);
            if (i == 8) wr(`TFT_OFF_TX_ESC, 32'h0);
            if (i >= 9) begin
                repeat (4) @(posedge mclk_in);
                #1;
                compare(rx_lk, 1);
                compare(rx_fs, 1);
                compare(rx_sf, n == 1);
            end
            wait_lvl(1'h0);
            if (i == 11) wr(`TFT_OFF_MODE, 32'h1);
        end
        final_report();
    end
endmodule
`default_nettype wire
